/* design/sra_pkg.sv */
package sra_pkg;

    // ****************************************
    // Register map and field layout
    // ****************************************
    localparam logic [7:0] OFF_ID_WORD     = 8'h00;
    localparam logic [7:0] OFF_ROM_ACCESS  = 8'h04;
    localparam int         ID_PRESENT_BIT  = 24;
    localparam logic [7:0] ID_MAJOR_VER    = 8'h01;
    localparam logic [7:0] ID_MINOR_VER    = 8'h00;
    localparam int         ROM_CLEAR_BIT   = 31;
    localparam int         ROM_TRIG_BIT    = 25;
    localparam int         BE_TOP_LANE     = 3;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;

    // ****************************************
    // Sizes of the identifier store
    // ****************************************
    localparam int         ROM_AW          = 8;
    localparam int         BIB_BYTES       = 20;
    localparam int         BIB_AW          = 5;
    localparam logic [4:0] BIB_LAST        = 5'h13;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [6:0] {
        S_DETECT     = 7'h01,
        S_IDLE       = 7'h02,
        S_CLEAR      = 7'h04,
        S_FETCH_REQ  = 7'h08,
        S_FETCH_WAIT = 7'h10,
        S_BOOT_REQ   = 7'h20,
        S_BOOT_WAIT  = 7'h40
    } sra_state_t;

    typedef struct packed {
        logic              start;
        logic [ROM_AW-1:0] addr;
    } sra_rom_req_t;

    typedef struct packed {
        logic       done;
        logic [7:0] data;
    } sra_rom_rsp_t;

    typedef struct packed {
        logic              we;
        logic [BIB_AW-1:0] addr;
        logic [7:0]        data;
    } sra_mem_wr_t;

    // ****************************************
    // Read words
    // ****************************************
    function automatic logic [31:0] sra_id_word(input logic present);
        sra_id_word = {7'h00, present, ID_MAJOR_VER, 8'h00, ID_MINOR_VER};
    endfunction : sra_id_word

    function automatic logic [31:0] sra_rom_word(input logic clr, input logic trig,
                                                 input logic [7:0] data);
        sra_rom_word = {clr, 5'h00, trig, 1'h0, data, 16'h0000};
    endfunction : sra_rom_word

endpackage : sra_pkg

/* design/sra_bib_mem.sv */
module sra_bib_mem
    import sra_pkg::*;
(
    // Clock and reset
    input  logic              ref_clk,
    input  logic              reset_n,
    // Write port
    input  sra_mem_wr_t       wr,
    // Read port
    input  logic [BIB_AW-1:0] rd_addr,
    output logic [7:0]        rd_data
);

    typedef struct packed {
        logic [BIB_BYTES-1:0][7:0] cells;
        logic [7:0]                rdata;
    } sra_mem_st_t;

    sra_mem_st_t st;
    sra_mem_st_t next_st;

    always_comb
    begin
        next_st = st;
        if (wr.we && wr.addr <= BIB_LAST)
        begin
            next_st.cells[wr.addr] = wr.data;
        end
        // Out of range reads give zero rather than an undefined cell
        next_st.rdata = (rd_addr <= BIB_LAST) ? st.cells[rd_addr] : 8'h00;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign rd_data = st.rdata;

endmodule : sra_bib_mem

/* design/sra_rom_port.sv */
module sra_rom_port
    import sra_pkg::*;
(
    // Clock and reset
    input  logic              ref_clk,
    input  logic              reset_n,
    // Engine side
    input  sra_rom_req_t      req,
    output sra_rom_rsp_t      rsp,
    // Byte reader side
    output logic              rom_rd_req,
    output logic [ROM_AW-1:0] rom_rd_addr,
    input  logic              rom_rd_ack,
    input  logic [7:0]        rom_rd_data
);

    typedef struct packed {
        logic              busy;
        logic [ROM_AW-1:0] addr;
        sra_rom_rsp_t      rsp;
    } sra_port_st_t;

    sra_port_st_t st;
    sra_port_st_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.rsp.done = 1'b0;
        if (st.busy && rom_rd_ack)
        begin
            next_st.busy = 1'b0;
            next_st.rsp.done = 1'b1;
            next_st.rsp.data = rom_rd_data;
        end
        else if (!st.busy && req.start)
        begin
            next_st.busy = 1'b1;
            next_st.addr = req.addr;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign rsp         = st.rsp;
    assign rom_rd_req  = st.busy;
    assign rom_rd_addr = st.addr;

    // ****************************************
    // Checks
    // ****************************************
    a_req_held_addr: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st.busy && !rom_rd_ack |=> st.busy && $stable(st.addr))
        else $error("byte request dropped before acknowledge");

    a_done_one_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st.rsp.done |=> !st.rsp.done)
        else $error("done held longer than one cycle");

endmodule : sra_rom_port

/* design/sra_access_top.sv */
// Summary of operation
// - Identification word bits 31..25 always read zero.
// - Bit 24 of identification word shows a detected identifier EEPROM.
// - With EEPROM present, bus information block loads by itself after reset.
// - Identification bits 23..16 read major version 01h.
// - Identification bits 7..0 read minor revision 00h.
// - Identification bits 15..8 read zero.
// - Writing one to bit 31 clears byte address; bit drops when done.
// - Address clear does not fetch byte zero into the read field.
// - Writing one to bit 25 starts reading the currently addressed byte.
// - Bit 25 clears itself when the byte read finishes.
// - Each finished read puts its byte into bits 23..16.
// - Access register bits 30..26, 24 and 15..0 read zero.
module sra_access_top
    import sra_pkg::*;
(
    // Clock and reset
    input  logic              ref_clk,
    input  logic              reset_n,
    // Register bus
    input  logic [7:0]        avs_address,
    input  logic              avs_read,
    input  logic              avs_write,
    input  logic [3:0]        avs_byteenable,
    input  logic [31:0]       avs_writedata,
    output logic [31:0]       avs_readdata,
    output logic [1:0]        avs_response,
    output logic              avs_waitrequest,
    // Identifier EEPROM byte reader
    input  logic              rom_detect,
    output logic              rom_rd_req,
    output logic [ROM_AW-1:0] rom_rd_addr,
    input  logic              rom_rd_ack,
    input  logic [7:0]        rom_rd_data,
    // Bus information block
    input  logic [BIB_AW-1:0] bib_rd_addr,
    output logic [7:0]        bib_rd_data,
    output logic              bib_loaded,
    output logic              rom_present_flag
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        sra_state_t        fsm;
        logic              present;
        logic              rom_address_clear;
        logic              rom_read_trigger;
        logic [7:0]        rom_read_byte;
        logic [ROM_AW-1:0] rom_addr;
        logic [BIB_AW-1:0] boot_idx;
        logic              loaded;
        logic              waitrequest;
        logic [31:0]       readdata;
        logic [1:0]        response;
    } sra_top_st_t;

    sra_top_st_t  st;
    sra_top_st_t  next_st;
    sra_rom_req_t rom_req;
    sra_rom_rsp_t rom_rsp;
    sra_mem_wr_t  mem_wr;
    logic         take;
    logic         hit_id;
    logic         hit_rom;
    logic         set_lane;

    assign take     = (avs_read || avs_write) && st.waitrequest;
    assign hit_id   = (avs_address == OFF_ID_WORD);
    assign hit_rom  = (avs_address == OFF_ROM_ACCESS);
    assign set_lane = take && avs_write && hit_rom && avs_byteenable[BE_TOP_LANE];

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        next_st = st;
        rom_req = '0;
        mem_wr  = '0;

        // Answer one cycle after the request is seen, then release
        next_st.waitrequest = !take;
        if (take)
        begin
            next_st.response = RESP_OKAY;
            next_st.readdata = 32'h0000_0000;
            if (hit_id)
            begin
                if (avs_read)
                begin
                    next_st.readdata = sra_id_word(st.present);
                end
            end
            else if (hit_rom)
            begin
                if (avs_read)
                begin
                    next_st.readdata = sra_rom_word(st.rom_address_clear,
                                                    st.rom_read_trigger,
                                                    st.rom_read_byte);
                end
            end
            else
            begin
                next_st.response = RESP_SLVERR;
            end
        end

        unique case (st.fsm)
            S_DETECT:
            begin
                // Strap style capture in the first cycle after reset
                next_st.present = rom_detect;
                next_st.fsm = rom_detect ? S_BOOT_REQ : S_IDLE;
            end
            S_IDLE:
            begin
                if (!st.present)
                begin
                    // No EEPROM: requests complete at once so polling ends
                    next_st.rom_address_clear = 1'b0;
                    next_st.rom_read_trigger  = 1'b0;
                end
                else if (st.rom_address_clear)
                begin
                    next_st.fsm = S_CLEAR;
                end
                else if (st.rom_read_trigger)
                begin
                    next_st.fsm = S_FETCH_REQ;
                end
            end
            S_CLEAR:
            begin
                // Read field left alone on purpose
                next_st.rom_addr = '0;
                next_st.rom_address_clear = 1'b0;
                next_st.fsm = S_IDLE;
            end
            S_FETCH_REQ:
            begin
                rom_req.start = 1'b1;
                rom_req.addr  = st.rom_addr;
                next_st.fsm = S_FETCH_WAIT;
            end
            S_FETCH_WAIT:
            begin
                if (rom_rsp.done)
                begin
                    next_st.rom_read_byte = rom_rsp.data;
                    next_st.rom_addr = st.rom_addr + ROM_AW'(1);
                    next_st.rom_read_trigger = 1'b0;
                    next_st.fsm = S_IDLE;
                end
            end
            S_BOOT_REQ:
            begin
                rom_req.start = 1'b1;
                rom_req.addr  = ROM_AW'(st.boot_idx);
                next_st.fsm = S_BOOT_WAIT;
            end
            S_BOOT_WAIT:
            begin
                if (rom_rsp.done)
                begin
                    mem_wr.we   = 1'b1;
                    mem_wr.addr = st.boot_idx;
                    mem_wr.data = rom_rsp.data;
                    if (st.boot_idx == BIB_LAST)
                    begin
                        next_st.loaded = 1'b1;
                        next_st.fsm = S_IDLE;
                    end
                    else
                    begin
                        next_st.boot_idx = st.boot_idx + BIB_AW'(1);
                        next_st.fsm = S_BOOT_REQ;
                    end
                end
            end
        endcase

        // Software sets last so a set beats a same-cycle completion
        if (set_lane && avs_writedata[ROM_CLEAR_BIT])
        begin
            next_st.rom_address_clear = 1'b1;
        end
        if (set_lane && avs_writedata[ROM_TRIG_BIT])
        begin
            next_st.rom_read_trigger = 1'b1;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            st             <= '0;
            st.fsm         <= S_DETECT;
            st.waitrequest <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign avs_readdata     = st.readdata;
    assign avs_response     = st.response;
    assign avs_waitrequest  = st.waitrequest;
    assign bib_loaded       = st.loaded;
    assign rom_present_flag = st.present;

    // ****************************************
    // Submodules
    // ****************************************
    sra_rom_port u_rom_port (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .req         (rom_req),
        .rsp         (rom_rsp),
        .rom_rd_req  (rom_rd_req),
        .rom_rd_addr (rom_rd_addr),
        .rom_rd_ack  (rom_rd_ack),
        .rom_rd_data (rom_rd_data)
    );

    sra_bib_mem u_bib_mem (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .wr      (mem_wr),
        .rd_addr (bib_rd_addr),
        .rd_data (bib_rd_data)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    a_id_top_zero: assert property (
        avs_read && hit_id && st.waitrequest |=> avs_readdata[31:25] == 7'h00)
        else $error("identification top bits not zero");

    a_id_present_bit: assert property (
        avs_read && hit_id && st.waitrequest |=> avs_readdata[24] == st.present)
        else $error("presence bit does not match detection");

    a_boot_starts: assert property (
        reset_n && st.fsm == S_DETECT && rom_detect
        |=> st.fsm == S_BOOT_REQ && rom_req.start ##1 rom_rd_req)
        else $error("block load not started after reset");

    a_id_major_ver: assert property (
        avs_read && hit_id && st.waitrequest |=> avs_readdata[23:16] == ID_MAJOR_VER)
        else $error("major version wrong");

    a_id_minor_ver: assert property (
        avs_read && hit_id && st.waitrequest |=> avs_readdata[7:0] == ID_MINOR_VER)
        else $error("minor revision wrong");

    a_id_mid_zero: assert property (
        avs_read && hit_id && st.waitrequest |=> avs_readdata[15:8] == 8'h00)
        else $error("identification bits 15..8 not zero");

    a_clear_addr_zero: assert property (
        st.fsm == S_CLEAR |=> st.rom_addr == '0 && st.fsm == S_IDLE)
        else $error("address clear did not reach zero");

    a_clear_keeps_byte: assert property (
        st.fsm == S_CLEAR |=> $stable(st.rom_read_byte))
        else $error("address clear changed the read byte");

    a_trigger_fetches: assert property (
        st.fsm == S_IDLE && st.present && st.rom_read_trigger && !st.rom_address_clear
        |=> st.fsm == S_FETCH_REQ ##1 rom_rd_req)
        else $error("read trigger did not start a fetch");

    a_trigger_self_clear: assert property (
        $fell(st.rom_read_trigger) |-> $past(st.fsm == S_FETCH_WAIT && rom_rsp.done)
        || $past(!st.present))
        else $error("read trigger cleared without completion");

    a_byte_captured: assert property (
        st.fsm == S_FETCH_WAIT && rom_rsp.done |=> st.rom_read_byte == $past(rom_rsp.data))
        else $error("fetched byte not placed in read field");

    a_access_resv_zero: assert property (
        avs_read && hit_rom && st.waitrequest
        |=> avs_readdata[30:26] == 5'h00 && !avs_readdata[24] && avs_readdata[15:0] == 16'h0000)
        else $error("access register reserved bits not zero");

    a_zero_write_inert: assert property (
        take && avs_write && hit_rom && !avs_writedata[ROM_TRIG_BIT] && st.rom_read_trigger
        && !rom_rsp.done && st.present |=> st.rom_read_trigger)
        else $error("writing zero cleared the read trigger");

    a_addr_advances: assert property (
        st.fsm == S_FETCH_WAIT && rom_rsp.done
        |=> st.rom_addr == ROM_AW'($past(st.rom_addr) + ROM_AW'(1)))
        else $error("byte address did not step after read");

endmodule : sra_access_top

/* tb/sra_rom_model.sv */
module sra_rom_model
    import sra_pkg::*;
(
    // Clock
    input  logic              ref_clk,
    // Byte reader link
    input  logic              rom_rd_req,
    input  logic [ROM_AW-1:0] rom_rd_addr,
    output logic              rom_rd_ack,
    output logic [7:0]        rom_rd_data,
    // Answer speed in cycles
    input  logic [3:0]        delay
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [256];
    logic [3:0] wait_cnt;

    initial
    begin
        rom_rd_ack  = 1'b0;
        rom_rd_data = 8'h00;
        wait_cnt    = 4'h0;
        foreach (mem[i])
            mem[i] = 8'(i * 29 + 55);
    end

    // Idle data line toggles so a stale byte never looks valid
    always @(posedge ref_clk)
    begin
        rom_rd_ack <= 1'b0;
        if (rom_rd_req && !rom_rd_ack && wait_cnt >= delay)
        begin
            rom_rd_ack  <= 1'b1;
            rom_rd_data <= mem[rom_rd_addr];
            wait_cnt    <= 4'h0;
        end
        else
        begin
            rom_rd_data <= ~rom_rd_data;
            if (rom_rd_req && !rom_rd_ack)
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : sra_rom_model

/* tb/tb_serial_id_rom_access.sv */
module tb_serial_id_rom_access
    import sra_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              ref_clk;
    logic              reset_n;
    logic [7:0]        avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [3:0]        avs_byteenable;
    logic [31:0]       avs_writedata;
    logic [31:0]       avs_readdata;
    logic [1:0]        avs_response;
    logic              avs_waitrequest;
    logic              rom_detect;
    logic              rom_rd_req;
    logic [ROM_AW-1:0] rom_rd_addr;
    logic              rom_rd_ack;
    logic [7:0]        rom_rd_data;
    logic [BIB_AW-1:0] bib_rd_addr;
    logic [7:0]        bib_rd_data;
    logic              bib_loaded;
    logic              rom_present_flag;
    logic [3:0]        rom_delay;
    int                errors   = 0;
    int                compares = 0;

    sra_access_top DUT (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
        .rom_detect(rom_detect), .rom_rd_req(rom_rd_req), .rom_rd_addr(rom_rd_addr),
        .rom_rd_ack(rom_rd_ack), .rom_rd_data(rom_rd_data), .bib_rd_addr(bib_rd_addr),
        .bib_rd_data(bib_rd_data), .bib_loaded(bib_loaded),
        .rom_present_flag(rom_present_flag));

    sra_rom_model rom (.ref_clk(ref_clk), .rom_rd_req(rom_rd_req), .rom_rd_addr(rom_rd_addr),
        .rom_rd_ack(rom_rd_ack), .rom_rd_data(rom_rd_data), .delay(rom_delay));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_sim();
        if (errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rsp);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address    <= a;
        avs_read       <= !wr;
        avs_write      <= wr;
        avs_writedata  <= wd;
        avs_byteenable <= be;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            errors++;
        rd = avs_readdata;
        rsp = avs_response;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] d;
        logic [1:0]  r;
        bus(1'b1, a, wd, be, d, r);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rsp);
        logic [31:0] d;
        logic [1:0]  r;
        bus(1'b0, a, 32'h0000_0000, 4'hF, d, r);
        chk("read word", exp, d);
        chk("response", {30'h0, rsp}, {30'h0, r});
    endtask : rd_chk

    task automatic wait_done(input int bitn, output logic [31:0] d, output logic seen);
        int         n;
        logic [1:0] r;
        n = 0;
        do
        begin
            bus(1'b0, OFF_ROM_ACCESS, 32'h0000_0000, 4'hF, d, r);
            if (n == 0)
                seen = d[bitn];
            n++;
        end
        while (d[bitn] !== 1'b0 && n < 40);
        if (n >= 40)
            errors++;
    endtask : wait_done

    task automatic sw_fetch(input logic [31:0] cmd, input logic [7:0] exp);
        logic [31:0] d;
        logic        seen;
        wr(OFF_ROM_ACCESS, cmd, 4'hF);
        wait_done(ROM_TRIG_BIT, d, seen);
        chk("trigger pending", 32'h1, {31'h0, seen});
        chk("fetched word", {8'h00, exp, 16'h0000}, d);
    endtask : sw_fetch

    task automatic do_reset(input logic det);
        reset_n    <= 1'b0;
        rom_detect <= det;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
    endtask : do_reset

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_boot();
        int n;
        n = 0;
        while (bib_loaded !== 1'b1 && n < 400)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk("loaded", 32'h1, {31'h0, bib_loaded});
        chk("present flag", 32'h1, {31'h0, rom_present_flag});
        rd_chk(OFF_ID_WORD, 32'h0101_0000, RESP_OKAY);
        wr(OFF_ID_WORD, 32'hFFFF_FFFF, 4'hF);
        rd_chk(OFF_ID_WORD, 32'h0101_0000, RESP_OKAY);
        for (int i = 0; i <= BIB_BYTES; i++)
        begin
            bib_rd_addr <= 5'(i);
            repeat (2) @(posedge ref_clk);
            chk("info byte", {24'h0, i < BIB_BYTES ? rom.mem[i] : 8'h00}, {24'h0, bib_rd_data});
        end
    endtask : t_boot

    task automatic t_fetch();
        rom_delay <= 4'h5;
        sw_fetch(32'h0200_0000, rom.mem[0]);
        sw_fetch(32'h0200_0000, rom.mem[1]);
        sw_fetch(32'h0200_0000, rom.mem[2]);
    endtask : t_fetch

    task automatic t_zero_writes();
        logic [31:0] d;
        logic        seen;
        wr(OFF_ROM_ACCESS, 32'h7DFF_FFFF, 4'hF);
        rd_chk(OFF_ROM_ACCESS, {8'h00, rom.mem[2], 16'h0000}, RESP_OKAY);
        wr(OFF_ROM_ACCESS, 32'h0200_0000, 4'h7);
        rd_chk(OFF_ROM_ACCESS, {8'h00, rom.mem[2], 16'h0000}, RESP_OKAY);
        sw_fetch(32'h0200_0000, rom.mem[3]);
        // Slow answer so a zero write lands while the fetch is pending
        rom_delay <= 4'hF;
        wr(OFF_ROM_ACCESS, 32'h0200_0000, 4'hF);
        wr(OFF_ROM_ACCESS, 32'h7DFF_FFFF, 4'hF);
        wait_done(ROM_TRIG_BIT, d, seen);
        chk("trigger kept", 32'h1, {31'h0, seen});
        chk("fetched word", {8'h00, rom.mem[4], 16'h0000}, d);
    endtask : t_zero_writes

    task automatic t_clear();
        logic [31:0] d;
        logic        seen;
        rom_delay <= 4'h0;
        wr(OFF_ROM_ACCESS, 32'h8000_0000, 4'hF);
        wait_done(ROM_CLEAR_BIT, d, seen);
        chk("after clear", {8'h00, rom.mem[4], 16'h0000}, d);
        sw_fetch(32'h0200_0000, rom.mem[0]);
        sw_fetch(32'h0200_0000, rom.mem[1]);
        sw_fetch(32'h8200_0000, rom.mem[0]);
    endtask : t_clear

    task automatic t_absent();
        rd_chk(8'h08, 32'h0000_0000, RESP_SLVERR);
        do_reset(1'b0);
        repeat (3) @(posedge ref_clk);
        chk("absent flag", 32'h0, {31'h0, rom_present_flag});
        rd_chk(OFF_ID_WORD, 32'h0001_0000, RESP_OKAY);
    endtask : t_absent

    // ****************************************
    // Clock, watchdog and main sequence
    // ****************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Whole run needs a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        end_sim();
    end

    initial
    begin
        reset_n        = 1'b0;
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_byteenable = 4'hF;
        avs_writedata  = 32'h0000_0000;
        rom_detect     = 1'b1;
        bib_rd_addr    = 5'h00;
        rom_delay      = 4'h0;
        do_reset(1'b1);
        t_boot();
        t_fetch();
        t_zero_writes();
        t_clear();
        t_absent();
        end_sim();
    end
endmodule : tb_serial_id_rom_access
